/* File: include/rcr_pkg.sv */
// package for the reset cause recorder: register map, fields, event carriers
package rcr_pkg;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  OFS_FLAGS     = 4'h0;
    localparam logic [3:0]  OFS_IRQ_STAT  = 4'h4;
    localparam logic [3:0]  OFS_IRQ_MASK  = 4'h8;
    localparam logic [3:0]  OFS_WREG_INIT = 4'hc;
    localparam logic [3:0]  OFS_PROT      = 4'h0 + 4'h0;
    localparam int          BIT_TRAP      = 15;
    localparam int          BIT_ILLOP     = 14;
    localparam int          BIT_CFGMIS    = 9;
    localparam int          BIT_PIN       = 7;
    localparam int          BIT_SOFT      = 6;
    localparam int          BIT_WDT       = 4;
    localparam int          BIT_SLEEP     = 3;
    localparam int          BIT_IDLE      = 2;
    localparam int          BIT_BROWN     = 1;
    localparam int          BIT_POR       = 0;
    localparam logic [15:0] FLAGS_MASK    = 16'hc2df;
    localparam logic [15:0] FLAGS_RESET   = 16'h0003;
    localparam int          NUM_WREGS     = 16;
    localparam int          WREG_AW       = 4;
    localparam logic [3:0]  SP_INDEX      = 4'hf;
    localparam int          PC_W          = 24;
    localparam int          IRQ_BITS      = 3;
    localparam int          IRQ_UWREG     = 0;
    localparam int          IRQ_SECURITY  = 1;
    localparam int          IRQ_CAUSE     = 2;

    // core events, one-cycle pulses
    typedef struct packed {
        logic trap_conflict;
        logic illegal_opcode;
        logic config_mismatch;
        logic master_clear_pin;
        logic reset_instr;
        logic watchdog_timeout;
        logic power_save_sleep;
        logic power_save_idle;
        logic watchdog_clear_instr;
        logic por;
        logic bor;
    } rcr_event_type;

    // register and pointer use by the core
    typedef struct packed {
        logic               wr_valid;
        logic [WREG_AW-1:0] wr_index;
        logic               ptr_valid;
        logic [WREG_AW-1:0] ptr_index;
    } rcr_wreg_type;

    // pc reload reported by the core
    typedef struct packed {
        logic            program_flow_change;
        logic            vector_flow_change;
        logic [PC_W-1:0] target;
    } rcr_flow_type;
endpackage

/* File: hw/rcr_top.sv */
// reset cause recorder: cause flags, uninit-pointer and security resets, avalon slave
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - reset on pointer use of unwritten register
// - every reset marks registers uninitialized, not stack
// - security reset on flow into restricted location
// - calls, jumps, returns, branches are program flow
// - vector or trap reloads are vector flow
// - trap conflict bit 15, cleared by por/bor
// - illegal op bit 14, cleared by por/bor
// - config mismatch bit 9, cleared by por/bor
// - pin reset bit 7, cleared by por only
// - soft reset bit 6, cleared by por/bor
// - watchdog bit 4, cleared by instructions, por, bor
// - sleep bit 3, cleared by por/bor
// - idle bit 2, cleared by por/bor
// - brownout bit 1 set by por or bor
// - software may set and clear every flag
module rcr_top (
    input  wire logic                         sys_clk_in,
    input  wire logic                         rst_n_in,
    input  wire rcr_pkg::rcr_event_type       events_in,
    input  wire rcr_pkg::rcr_wreg_type        wreg_in,
    input  wire rcr_pkg::rcr_flow_type        flow_in,
    input  wire logic [rcr_pkg::PC_W-1:0]     prot_lo_in,
    input  wire logic [rcr_pkg::PC_W-1:0]     prot_hi_in,
    input  wire logic                         prot_en_in,
    input  wire logic                         sys_reset_in,
    input  wire logic [rcr_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [31:0]                  avs_readdata,
    output logic                              avs_waitrequest,
    // registered so every output comes from a flip-flop; uwreg_hit or sec_hit one edge later
    output logic                              dev_reset_out,
    output logic                              irq_out
);
    import rcr_pkg::*;

    logic [15:0]           flags_q;
    logic [15:0]           flags_d;
    logic [NUM_WREGS-1:0]  wreg_init_q;
    logic [IRQ_BITS-1:0]   irq_stat_q;
    logic [IRQ_BITS-1:0]   irq_mask_q;
    logic                  ack_q;
    logic                  uwreg_hit;
    logic                  sec_hit;
    logic                  any_reset;
    logic                  hw_cause;
    logic                  wr_flags;
    logic                  wr_stat;
    logic [15:0]           wmask;
    logic [15:0]           hw_set;
    logic [15:0]           hw_clr;
    logic [IRQ_BITS-1:0]   irq_ev;

    // one wait cycle: request accepted at second edge
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_comb begin
        wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wr_flags = avs_write && ack_q && (avs_address == OFS_FLAGS);
        wr_stat  = avs_write && ack_q && (avs_address == OFS_IRQ_STAT);
    end

    // pointer through a register not written since reset
    always_comb begin
        uwreg_hit = wreg_in.ptr_valid && !wreg_init_q[wreg_in.ptr_index];
    end

    // flow reload landing in the protected window
    always_comb begin
        sec_hit = prot_en_in
            && (flow_in.program_flow_change || flow_in.vector_flow_change)
            && (flow_in.target >= prot_lo_in) && (flow_in.target <= prot_hi_in);
    end

    always_comb begin
        hw_cause  = events_in.illegal_opcode || uwreg_hit || sec_hit;
        any_reset = sys_reset_in || hw_cause || events_in.trap_conflict
            || events_in.config_mismatch || events_in.master_clear_pin
            || events_in.reset_instr || events_in.watchdog_timeout
            || events_in.por || events_in.bor;
    end

    always_comb begin
        hw_set = 16'h0000;
        hw_clr = 16'h0000;
        hw_set[BIT_TRAP]   = events_in.trap_conflict;
        hw_set[BIT_ILLOP]  = hw_cause;
        hw_set[BIT_CFGMIS] = events_in.config_mismatch;
        hw_set[BIT_PIN]    = events_in.master_clear_pin;
        hw_set[BIT_SOFT]   = events_in.reset_instr;
        hw_set[BIT_WDT]    = events_in.watchdog_timeout;
        hw_set[BIT_SLEEP]  = events_in.power_save_sleep;
        hw_set[BIT_IDLE]   = events_in.power_save_idle;
        hw_set[BIT_BROWN]  = events_in.por || events_in.bor;
        hw_set[BIT_POR]    = events_in.por;
        if (events_in.por || events_in.bor) begin
            // pin flag survives brownout
            hw_clr = FLAGS_MASK & ~16'h0003;
            hw_clr[BIT_PIN] = events_in.por;
        end
        if (events_in.power_save_sleep || events_in.power_save_idle
            || events_in.watchdog_clear_instr) begin
            hw_clr[BIT_WDT] = 1'b1;
        end
        // a cause event on the same edge overrides por/bor and watchdog clears of the bit it sets
        hw_clr = hw_clr & ~hw_set;
    end

    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = (flags_q & ~wmask) | (avs_writedata[15:0] & wmask);
        end
        // hardware last, so it wins
        flags_d = ((flags_d & ~hw_clr) | hw_set) & FLAGS_MASK;
    end

    // flags load FLAGS_RESET on rst_n_in, otherwise change only by core events and software; sys_reset_in leaves them
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // init tracking per working register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WREGS; gi++) begin : g_wreg
            always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    wreg_init_q[gi] <= (gi == SP_INDEX);
                end else if (any_reset) begin
                    wreg_init_q[gi] <= (gi == SP_INDEX);
                end else if (wreg_in.wr_valid && wreg_in.wr_index == gi) begin
                    wreg_init_q[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_reset_out <= 1'b0;
        end else begin
            dev_reset_out <= uwreg_hit || sec_hit;
        end
    end

    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_UWREG]    = uwreg_hit;
        irq_ev[IRQ_SECURITY] = sec_hit;
        irq_ev[IRQ_CAUSE]    = |hw_set;
    end

    // write one to clear; a new event wins
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= '0;
        end else if (wr_stat) begin
            irq_stat_q <= (irq_stat_q & ~avs_writedata[IRQ_BITS-1:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask_q <= '0;
        end else if (avs_write && ack_q && avs_address == OFS_IRQ_MASK) begin
            irq_mask_q <= avs_writedata[IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data registered at the first edge, while ack_q is low, one edge before acceptance; unmapped reads zero
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                OFS_FLAGS:     avs_readdata <= {16'h0000, flags_q};
                OFS_IRQ_STAT:  avs_readdata <= {29'h0, irq_stat_q};
                OFS_IRQ_MASK:  avs_readdata <= {29'h0, irq_mask_q};
                OFS_WREG_INIT: avs_readdata <= {16'h0000, wreg_init_q};
                default:       avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    a_uwreg_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wreg_in.ptr_valid && !wreg_init_q[wreg_in.ptr_index]) |=> dev_reset_out)
        else $error("uninit pointer did not reset");
    a_sp_kept: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        any_reset |=> wreg_init_q == (16'h1 << SP_INDEX))
        else $error("register init not cleared");
    a_sec_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        sec_hit |=> dev_reset_out && flags_q[BIT_ILLOP])
        else $error("security reset missing");
    a_trap_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        events_in.trap_conflict |=> flags_q[BIT_TRAP])
        else $error("trap flag not set");
    a_pin_keep: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (events_in.bor && !events_in.por && !wr_flags && flags_q[BIT_PIN])
        |=> flags_q[BIT_PIN])
        else $error("pin flag lost on brownout");
    a_wdt_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (events_in.watchdog_clear_instr && !events_in.watchdog_timeout)
        |=> !flags_q[BIT_WDT])
        else $error("watchdog flag not cleared");
    a_por_bits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        events_in.por |=> flags_q[BIT_POR] && flags_q[BIT_BROWN])
        else $error("power-on bits not set");
    a_hw_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wr_flags && events_in.reset_instr) |=> flags_q[BIT_SOFT])
        else $error("write beat hardware set");
    a_sw_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wr_flags && avs_byteenable == 4'hf && hw_set == 16'h0 && hw_clr == 16'h0)
        |=> flags_q == (avs_writedata[15:0] & FLAGS_MASK))
        else $error("software write lost");
endmodule // rcr_top

/* File: testbench/rcr_core_model.sv */
// core model: one-cycle event, register and flow pulses into the recorder
`timescale 1ns/1ps
module rcr_core_model (
    input  wire logic              sys_clk_in,
    output rcr_pkg::rcr_event_type events_out,
    output rcr_pkg::rcr_wreg_type  wreg_out,
    output rcr_pkg::rcr_flow_type  flow_out
);
    import rcr_pkg::*;
    initial begin
        events_out = '0;
        wreg_out   = '0;
        flow_out   = '0;
    end
    // target scrambled after the pulse so a stale value never matches
    task automatic pulse(input rcr_event_type e, input rcr_wreg_type w, input rcr_flow_type f);
        @(posedge sys_clk_in);
        events_out <= e;
        wreg_out   <= w;
        flow_out   <= f;
        @(posedge sys_clk_in);
        events_out <= '0;
        wreg_out   <= '0;
        flow_out   <= '{1'b0, 1'b0, ~f.target};
    endtask
endmodule // rcr_core_model

/* File: testbench/tb_rcr_top.sv */
// self-checking bench for the reset cause recorder
`timescale 1ns/1ps
module tb_rcr_top;
    import rcr_pkg::*;
    logic          sys_clk_in = 1'b0;
    logic          rst_n_in   = 1'b0;
    rcr_event_type ev;
    rcr_wreg_type  wr;
    rcr_flow_type  fl;
    logic          prot_en  = 1'b1;
    logic          sys_reset = 1'b0;
    logic [3:0]    avs_address = 4'h0;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [31:0]   avs_writedata = 32'h0;
    logic [31:0]   avs_readdata;
    logic [31:0]   rd;
    logic          avs_waitrequest;
    logic          dev_reset_out;
    logic          irq_out;
    int            errors = 0;
    int            samples_checked = 0;
    always #2 sys_clk_in = ~sys_clk_in;
    rcr_core_model core (.sys_clk_in(sys_clk_in), .events_out(ev), .wreg_out(wr), .flow_out(fl));
    rcr_top dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .events_in(ev), .wreg_in(wr),
        .flow_in(fl), .prot_lo_in(24'h000100), .prot_hi_in(24'h0001ff), .prot_en_in(prot_en),
        .sys_reset_in(sys_reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dev_reset_out(dev_reset_out), .irq_out(irq_out));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // holds the request until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int   n;
        n = 0;
        @(posedge sys_clk_in);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        // waitrequest read at the edge itself, before that edge's updates
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
            errors++;
            tally_and_finish();
        end else begin
            rd = avs_readdata;
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic hit(input rcr_event_type e, input rcr_wreg_type w, input rcr_flow_type f,
                       input logic exp);
        core.pulse(e, w, f);
        #1 chk("dev_reset_out", {31'h0, exp}, {31'h0, dev_reset_out});
    endtask
    task automatic t_reset();
        rdchk("flags at reset", OFS_FLAGS, 32'h0003);
        rdchk("unmapped", 4'h2, 32'h0);
        bus(1'b1, OFS_FLAGS, 32'hffff);
        rdchk("flags all set", OFS_FLAGS, 32'hc2df);
        bus(1'b1, OFS_FLAGS, 32'h0);
        rdchk("flags cleared", OFS_FLAGS, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_uninit();
        hit('0, '{1'b1, 4'h5, 1'b0, 4'h0}, '0, 1'b0);
        hit('0, '{1'b0, 4'h0, 1'b1, 4'h5}, '0, 1'b0);
        hit('0, '{1'b0, 4'h0, 1'b1, SP_INDEX}, '0, 1'b0);
        hit('0, '{1'b0, 4'h0, 1'b1, 4'h3}, '0, 1'b1);
        rdchk("illegal flag", OFS_FLAGS, 32'h4000);
        hit('0, '{1'b0, 4'h0, 1'b1, 4'h5}, '0, 1'b1);
        hit('0, '{1'b1, 4'h6, 1'b0, 4'h0}, '0, 1'b0);
        @(posedge sys_clk_in);
        sys_reset <= 1'b1;
        @(posedge sys_clk_in);
        sys_reset <= 1'b0;
        hit('0, '{1'b0, 4'h0, 1'b1, 4'h6}, '0, 1'b1);
        bus(1'b1, OFS_FLAGS, 32'h0);
        $display("test uninit done");
    endtask
    task automatic t_secure();
        hit('0, '0, '{1'b1, 1'b0, 24'h000100}, 1'b1);
        hit('0, '0, '{1'b1, 1'b0, 24'h000200}, 1'b0);
        hit('0, '0, '{1'b0, 1'b1, 24'h0001ff}, 1'b1);
        hit('0, '0, '{1'b0, 1'b1, 24'h0000ff}, 1'b0);
        rdchk("security flag", OFS_FLAGS, 32'h4000);
        @(posedge sys_clk_in);
        prot_en <= 1'b0;
        hit('0, '0, '{1'b1, 1'b0, 24'h000150}, 1'b0);
        bus(1'b1, OFS_FLAGS, 32'h0);
        $display("test security done");
    endtask
    task automatic t_events();
        int pos [8] = '{15, 14, 9, 7, 6, 4, 3, 2};
        for (int i = 0; i < 8; i++) begin
            hit(11'h400 >> i, '0, '0, 1'b0);
            rdchk("flag set", OFS_FLAGS, 32'h1 << pos[i]);
            bus(1'b1, OFS_FLAGS, 32'h0);
        end
        bus(1'b1, OFS_FLAGS, 32'hc2dc);
        hit(11'h001, '0, '0, 1'b0);
        rdchk("after brownout", OFS_FLAGS, 32'h0082);
        hit(11'h002, '0, '0, 1'b0);
        rdchk("after power-on", OFS_FLAGS, 32'h0003);
        bus(1'b1, OFS_FLAGS, 32'h0010);
        hit(11'h004, '0, '0, 1'b0);
        rdchk("after wdt clear", OFS_FLAGS, 32'h0);
        bus(1'b1, OFS_FLAGS, 32'h0010);
        hit(11'h010, '0, '0, 1'b0);
        rdchk("after sleep", OFS_FLAGS, 32'h0008);
        bus(1'b1, OFS_FLAGS, 32'h0010);
        hit(11'h008, '0, '0, 1'b0);
        rdchk("after idle", OFS_FLAGS, 32'h0004);
        $display("test events done");
    endtask
    task automatic t_irq();
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        bus(1'b1, OFS_IRQ_MASK, 32'h4);
        hit(11'h400, '0, '0, 1'b0);
        rdchk("irq status", OFS_IRQ_STAT, 32'h4);
        #1 chk("irq_out", 32'h1, {31'h0, irq_out});
        bus(1'b1, OFS_IRQ_STAT, 32'h4);
        rdchk("irq status cleared", OFS_IRQ_STAT, 32'h0);
        #1 chk("irq_out", 32'h0, {31'h0, irq_out});
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        hit(11'h400, '0, '0, 1'b0);
        rdchk("irq status", OFS_IRQ_STAT, 32'h4);
        #1 chk("irq_out masked", 32'h0, {31'h0, irq_out});
        $display("test irq done");
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_uninit();
        t_secure();
        t_events();
        t_irq();
        tally_and_finish();
    end
endmodule // tb_rcr_top
